//--- rts_defs.vh
// register offsets, reset values and state codes of the radio test and status bank
`ifndef RTS_DEFS_VH
`define RTS_DEFS_VH
`define RTS_ADDR_SYNTH_TEST 6'h29
`define RTS_ADDR_PROD_TEST 6'h2a
`define RTS_ADDR_MISC_TWO 6'h2c
`define RTS_ADDR_MISC_ONE 6'h2d
`define RTS_ADDR_MISC_ZERO 6'h2e
`define RTS_ADDR_PART_ID 6'h30
`define RTS_ADDR_REV_ID 6'h31
`define RTS_ADDR_STATE_RPT 6'h35
`define RTS_RST_SYNTH_TEST 8'h57
`define RTS_RST_PROD_TEST 8'h7f
`define RTS_PROD_TEST_TEMP_EN 8'hbf
`define RTS_RST_MISC_TWO 8'h98
`define RTS_RST_MISC_ONE 8'h31
`define RTS_RST_MISC_ZERO 8'h0b
`define RTS_STATE_MSB 4
`define RTS_ST_SLEEP 5'h00
`define RTS_ST_IDLE 5'h01
`define RTS_ST_CRYSTAL_STOPPED 5'h02
`define RTS_ST_MANUAL_CAL_OSC_UP 5'h03
`define RTS_ST_MANUAL_CAL_REG_UP 5'h04
`define RTS_ST_MANUAL_CALIBRATION 5'h05
`define RTS_ST_OSCILLATOR_POWERING 5'h06
`define RTS_ST_REGULATOR_POWERING 5'h07
`define RTS_ST_CALIBRATION_BEGIN 5'h08
`define RTS_ST_LOOP_BW_BOOST 5'h09
`define RTS_ST_SYNTH_LOCKING 5'h0a
`define RTS_ST_CONVERTER_POWERING 5'h0b
`define RTS_ST_CALIBRATION_FINISH 5'h0c
`define RTS_ST_SYNTH_READY_FOR_SEND 5'h12
`define RTS_ST_TRANSMITTING 5'h13
`define RTS_ST_TRANSMIT_ENDING 5'h14
`define RTS_ST_TRANSMIT_UNDERFLOW 5'h16
`endif

//--- rts_regs.v
// test, identification and radio state report register bank
`timescale 1ns/1ps
`include "rts_defs.vh"

// Summary of operation
// - synth test word resets 0x57, test only
// - 0xbf in production word enables idle temp sensor
// - three misc test words reset 0x98/0x31/0x0b
// - read-only part and revision identifiers
// - state code bits 4:0, upper bits zero
// - state codes for sleep through calibration end and the transmit path
module rts_regs #(
    parameter [7:0] PART_ID = 8'h5a, // arbitrary value
    parameter [7:0] REV_ID = 8'h01 // arbitrary value
) (
    input wire clk,
    input wire reset,
    input wire wr_en,
    input wire rd_en,
    input wire [5:0] addr,
    input wire [7:0] wr_data,
    input wire [4:0] radio_fsm_code,
    output reg [7:0] rd_data_q,
    output reg rd_valid_q,
    output reg temp_sensor_en_q,
    output reg [7:0] synth_test_word_q,
    output reg [7:0] misc_test_word_two_q,
    output reg [7:0] misc_test_word_one_q,
    output reg [7:0] misc_test_word_zero_q
);
    // storage and state kept inside the bank
    // of the test words, only the production word is not brought out as a port
    reg [7:0] production_test_word_q;
    // state code as seen at the previous edge
    reg [4:0] state_q;
    // read value of the addressed register
    reg [7:0] rd_mux;
    // high while the reported state is idle
    reg state_is_idle;

    // address decode results
    // the selects are mutually exclusive by construction
    wire sel_synth;
    wire sel_prod;
    wire sel_two;
    wire sel_one;
    wire sel_zero;
    wire sel_part;
    wire sel_rev;
    wire sel_state;

    // write strobes of the writable registers
    wire wr_synth;
    wire wr_prod;
    wire wr_two;
    wire wr_one;
    wire wr_zero;

    // read terms, zero unless their register is addressed
    reg [7:0] term_synth;
    reg [7:0] term_prod;
    reg [7:0] term_two;
    reg [7:0] term_one;
    reg [7:0] term_zero;
    reg [7:0] term_part;
    reg [7:0] term_rev;
    reg [7:0] term_state;

    // sensor enable code match on the production word
    wire temp_code_match;

    // synth test word address
    assign sel_synth = (addr == `RTS_ADDR_SYNTH_TEST);
    // production test word address
    assign sel_prod = (addr == `RTS_ADDR_PROD_TEST);
    // misc test word two address
    assign sel_two = (addr == `RTS_ADDR_MISC_TWO);
    // misc test word one address
    assign sel_one = (addr == `RTS_ADDR_MISC_ONE);
    // misc test word zero address
    assign sel_zero = (addr == `RTS_ADDR_MISC_ZERO);
    assign sel_part = (addr == `RTS_ADDR_PART_ID);
    assign sel_rev = (addr == `RTS_ADDR_REV_ID);
    assign sel_state = (addr == `RTS_ADDR_STATE_RPT);

    // write strobes; read-only and unmapped addresses get none
    // so a write to an identifier or the report is dropped
    assign wr_synth = wr_en && sel_synth;
    assign wr_prod = wr_en && sel_prod;
    assign wr_two = wr_en && sel_two;
    assign wr_one = wr_en && sel_one;
    assign wr_zero = wr_en && sel_zero;

    // state code comes from same-clock radio logic, no synchroniser
    // one register stage keeps a read stable within its cycle
    // costs one cycle of latency on the report and the sensor gate
    always @(posedge clk) begin
        if (reset) begin
            state_q <= `RTS_ST_SLEEP;
        end else begin
            state_q <= radio_fsm_code;
        end
    end

    // every documented code decoded; only idle lets the sensor on
    // unused codes fall to the default and count as not idle
    // a glitchy code from the radio thus never enables the sensor
    always @* begin
        case (state_q)
            `RTS_ST_SLEEP: state_is_idle = 1'b0;
            `RTS_ST_IDLE: state_is_idle = 1'b1;
            `RTS_ST_CRYSTAL_STOPPED: state_is_idle = 1'b0;
            `RTS_ST_MANUAL_CAL_OSC_UP: state_is_idle = 1'b0;
            `RTS_ST_MANUAL_CAL_REG_UP: state_is_idle = 1'b0;
            `RTS_ST_MANUAL_CALIBRATION: state_is_idle = 1'b0;
            `RTS_ST_OSCILLATOR_POWERING: state_is_idle = 1'b0;
            `RTS_ST_REGULATOR_POWERING: state_is_idle = 1'b0;
            `RTS_ST_CALIBRATION_BEGIN: state_is_idle = 1'b0;
            `RTS_ST_LOOP_BW_BOOST: state_is_idle = 1'b0;
            `RTS_ST_SYNTH_LOCKING: state_is_idle = 1'b0;
            `RTS_ST_CONVERTER_POWERING: state_is_idle = 1'b0;
            `RTS_ST_CALIBRATION_FINISH: state_is_idle = 1'b0;
            // transmit path codes
            `RTS_ST_SYNTH_READY_FOR_SEND: state_is_idle = 1'b0;
            `RTS_ST_TRANSMITTING: state_is_idle = 1'b0;
            `RTS_ST_TRANSMIT_ENDING: state_is_idle = 1'b0;
            `RTS_ST_TRANSMIT_UNDERFLOW: state_is_idle = 1'b0;
            default: state_is_idle = 1'b0;
        endcase
    end

    // enable code match on the production word
    assign temp_code_match = (production_test_word_q == `RTS_PROD_TEST_TEMP_EN);

    // synth test word, reset value 0x57
    // test use only; normal firmware leaves it alone
    // no write protection, the host is trusted here
    always @(posedge clk) begin
        if (reset) begin
            synth_test_word_q <= `RTS_RST_SYNTH_TEST;
        end else if (wr_synth) begin
            synth_test_word_q <= wr_data;
        end
    end

    // production test word, reset value 0x7f
    // any value is stored; only the enable code has an effect
    // other values are test settings with no logic behind them
    always @(posedge clk) begin
        if (reset) begin
            production_test_word_q <= `RTS_RST_PROD_TEST;
        end else if (wr_prod) begin
            production_test_word_q <= wr_data;
        end
    end

    // misc test word two, reset value 0x98
    // the host loads tool values only
    // contents are passed out unchecked
    always @(posedge clk) begin
        if (reset) begin
            misc_test_word_two_q <= `RTS_RST_MISC_TWO;
        end else if (wr_two) begin
            misc_test_word_two_q <= wr_data;
        end
    end

    // misc test word one, reset value 0x31
    // the host loads tool values only
    // contents are passed out unchecked
    always @(posedge clk) begin
        if (reset) begin
            misc_test_word_one_q <= `RTS_RST_MISC_ONE;
        end else if (wr_one) begin
            misc_test_word_one_q <= wr_data;
        end
    end

    // misc test word zero, reset value 0x0b
    // the host loads tool values only
    // contents are passed out unchecked
    always @(posedge clk) begin
        if (reset) begin
            misc_test_word_zero_q <= `RTS_RST_MISC_ZERO;
        end else if (wr_zero) begin
            misc_test_word_zero_q <= wr_data;
        end
    end

    // sensor only in idle with enable code
    // sensor drops if host leaves idle without restoring
    // gating by state in hardware covers a host that forgets the restore
    // registered so the output comes straight from a flip-flop
    always @(posedge clk) begin
        if (reset) begin
            temp_sensor_en_q <= 1'b0;
        end else begin
            temp_sensor_en_q <= state_is_idle && temp_code_match;
        end
    end

    // read terms; an and-or mux keeps unmapped addresses at zero
    // without a default branch to forget
    // synth test word term
    always @* begin
        if (sel_synth) begin
            term_synth = synth_test_word_q;
        end else begin
            term_synth = 8'h00;
        end
    end

    // production test word term
    always @* begin
        if (sel_prod) begin
            term_prod = production_test_word_q;
        end else begin
            term_prod = 8'h00;
        end
    end

    // misc test word two term
    always @* begin
        if (sel_two) begin
            term_two = misc_test_word_two_q;
        end else begin
            term_two = 8'h00;
        end
    end

    // misc test word one term
    always @* begin
        if (sel_one) begin
            term_one = misc_test_word_one_q;
        end else begin
            term_one = 8'h00;
        end
    end

    // misc test word zero term
    always @* begin
        if (sel_zero) begin
            term_zero = misc_test_word_zero_q;
        end else begin
            term_zero = 8'h00;
        end
    end

    always @* begin
        if (sel_part) begin
            term_part = PART_ID;
        end else begin
            term_part = 8'h00;
        end
    end

    always @* begin
        if (sel_rev) begin
            term_rev = REV_ID;
        end else begin
            term_rev = 8'h00;
        end
    end

    // codes pass through unchanged, unused ones included
    always @* begin
        if (sel_state) begin
            term_state = {3'h0, state_q};
        end else begin
            term_state = 8'h00;
        end
    end

    // at most one term is nonzero since the selects are exclusive
    always @* begin
        rd_mux = term_synth | term_prod | term_two | term_one |
            term_zero | term_part | term_rev | term_state;
    end

    // read valid, one cycle after rd_en
    always @(posedge clk) begin
        if (reset) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_en;
        end
    end

    // read data registered on rd_en and held until the next read
    // a write in the same cycle is seen only by later reads
    // holding the byte lets a slow host pick it up late
    always @(posedge clk) begin
        if (reset) begin
            rd_data_q <= 8'h00;
        end else if (rd_en) begin
            rd_data_q <= rd_mux;
        end
    end
endmodule

//--- rts_host.sv
// host model on the register strobe port
`timescale 1ns/1ps
module rts_host(input clk, output reg wr_en = 0, output reg rd_en = 0,
    output reg [5:0] addr = 0, output reg [7:0] wr_data = 0);
    // one strobe cycle; lines scrambled when idle so stale values never pass
    task acc(input bit w, input [5:0] a, input [7:0] d);
        begin
            @(negedge clk);
            {wr_en, rd_en, addr, wr_data} = {w, !w, a, d};
            @(negedge clk);
            {wr_en, rd_en, addr, wr_data} = {2'h0, ~a, ~d};
        end
    endtask
endmodule

//--- rts_regs_checker.sv
// port assertions for the register bank
`timescale 1ns/1ps
module rts_regs_checker(input clk, reset, rd_en, rd_valid_q, temp_sensor_en_q,
    input [5:0] addr, input [4:0] radio_fsm_code, input [7:0] rd_data_q,
    input [7:0] synth_test_word_q, input [7:0] misc_test_word_zero_q);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // reset values, read path and sensor gating
    property p_rs; disable iff (1'b0) reset |=> synth_test_word_q == 8'h57; endproperty
    a_rs: assert property (p_rs) else $error("reset");
    property p_rz; disable iff (1'b0) reset |=> misc_test_word_zero_q == 8'h0b; endproperty
    a_rz: assert property (p_rz) else $error("reset");
    property p_id; rd_en && addr == 6'h30 |=> rd_data_q == 8'h5a; endproperty
    a_id: assert property (p_id) else $error("id");
    property p_st; rd_en && addr == 6'h35 |=> rd_data_q == {3'h0, $past(radio_fsm_code, 2)}; endproperty
    a_st: assert property (p_st) else $error("state");
    property p_ts; temp_sensor_en_q |-> $past(radio_fsm_code, 2) == 5'h01; endproperty
    a_ts: assert property (p_ts) else $error("sensor");
    property p_rv; rd_valid_q == $past(rd_en); endproperty
    a_rv: assert property (p_rv) else $error("valid");
    c_ts: cover property (temp_sensor_en_q);
    c_st: cover property (rd_en && addr == 6'h35);
    c_id: cover property (rd_en && addr == 6'h30);
endmodule
bind rts_regs rts_regs_checker u_chk(.*);

//--- tb_rts_regs.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; $display("wrong value %0t compare mismatch", $time); end end
module tb_rts_regs;
    reg clk = 0, reset = 1;
    reg [4:0] code = 1;
    reg [7:0] x;
    wire [7:0] rd, wd, sy, w2, w1, w0;
    wire v, ts, we, re;
    wire [5:0] ad;
    int error_cnt = 0, check_count = 0, seed = 43, i;
    rts_host u_host(.clk(clk), .wr_en(we), .rd_en(re), .addr(ad), .wr_data(wd));
    rts_regs u_dut(.clk(clk), .reset(reset), .wr_en(we), .rd_en(re), .addr(ad), .wr_data(wd),
        .radio_fsm_code(code), .rd_data_q(rd), .rd_valid_q(v), .temp_sensor_en_q(ts),
        .synth_test_word_q(sy), .misc_test_word_two_q(w2), .misc_test_word_one_q(w1),
        .misc_test_word_zero_q(w0));
    // free-running clock
    initial forever #5 clk = ~clk;
    // reset values; 0x2b is unmapped and reads zero
    function [7:0] rv(input [5:0] a);
        rv = a == 6'h29 ? 8'h57 : a == 6'h2a ? 8'h7f : a == 6'h2c ? 8'h98 : a == 6'h2d ? 8'h31 : a == 6'h2e ? 8'h0b : 8'h00;
    endfunction
    task rchk(input [5:0] a, input [7:0] e);
        begin
            u_host.acc(0, a, 8'h00);
            `CHK({v, rd}, {1'b1, e})
        end
    endtask
    task end_sim;
        begin
            $display("errors %0d checks %0d", error_cnt, check_count);
            if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    // watchdog against a hung handshake
    initial begin
        #100000;
        error_cnt++;
        end_sim;
    end
    // main sequence
    initial begin
        repeat (16) @(negedge clk);
        reset = 0;
        for (i = 0; i < 6; i++) rchk(6'(6'h29 + i), rv(6'(6'h29 + i)));
        `CHK(sy, 8'h57)
        for (i = 0; i < 9; i++) begin
            x = 8'($random(seed));
            u_host.acc(1, 6'(6'h2c + i % 3), x);
            rchk(6'(6'h2c + i % 3), x);
            `CHK(i % 3 == 0 ? w2 : i % 3 == 1 ? w1 : w0, x)
        end
        u_host.acc(1, 6'h30, 8'hff);
        rchk(6'h30, 8'h5a);
        rchk(6'h31, 8'h01);
        for (i = 0; i < 23; i++) begin
            code = 5'(i);
            rchk(6'h35, {3'h0, code});
        end
        code = 1;
        u_host.acc(1, 6'h2a, 8'hbf);
        repeat (2) @(negedge clk);
        `CHK(ts, 1'b1)
        code = 2;
        repeat (3) @(negedge clk);
        `CHK(ts, 1'b0)
        code = 1;
        u_host.acc(1, 6'h2a, 8'h7f);
        rchk(6'h2a, 8'h7f);
        `CHK(ts, 1'b0)
        end_sim;
    end
endmodule
